// [verilog/cwfc_pkg.sv]
package cwfc_pkg;
  localparam int CW             = 16;
  localparam int CLK_NS         = 50;
  // Filter and time-out figures in ns, then as cycle counts
  localparam int BUS_WAKE_NS    = 1000;
  localparam int PIN_WAKE_NS    = 30000;
  localparam int TXD_TO_NS      = 1000000;
  localparam int CLAMP_NS       = 100000;
  localparam int SHORT_NS       = 100000;
  localparam int SLEEP_ENTRY_NS = 50000;
  localparam int BIT_MIN_NS     = 4000;
  localparam int BUS_WAKE_CYC   = (BUS_WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int PIN_WAKE_CYC   = (PIN_WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int TXD_TO_CYC     = (TXD_TO_NS + CLK_NS - 1) / CLK_NS;
  localparam int CLAMP_CYC      = (CLAMP_NS + CLK_NS - 1) / CLK_NS;
  localparam int SHORT_CYC      = (SHORT_NS + CLK_NS - 1) / CLK_NS;
  localparam int SLEEP_CYC      = (SLEEP_ENTRY_NS + CLK_NS - 1) / CLK_NS;
  localparam int BIT_MIN_CYC    = (BIT_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] FAIL_BITS = 3'h4;

  // Positions of the synchronised pins
  localparam int P_SLPN = 0;
  localparam int P_EN   = 1;
  localparam int P_LWK  = 2;
  localparam int P_TXD  = 3;
  localparam int P_BUS  = 4;
  localparam int P_RXRB = 5;
  localparam int P_BFS  = 6;
  localparam int NPINS  = 7;
  // Filter reset value per pin; bus starts as dominant so a bus
  // already dominant at power-up never shows a rising edge
  localparam logic [NPINS-1:0] PIN_RST = 7'h38;

  typedef enum logic [4:0] {
    M_SLEEP = 5'h01,
    M_STBY  = 5'h02,
    M_GTS   = 5'h04,
    M_NORM  = 5'h08,
    M_RXO   = 5'h10
  } cwfc_mode_t;

  typedef struct packed {
    logic          s1;
    logic          s2;
    logic          lvl;
    logic [CW-1:0] cnt;
  } cwfc_filt_st_t;

  typedef struct packed {
    cwfc_mode_t mode;
    logic       wake_flag;
    logic       local_fail;
    logic       bus_fail;
  } cwfc_stat_t;

  typedef struct packed {
    cwfc_mode_t    mode;
    logic [CW-1:0] gts_cnt;
    logic          bus_prev;
    logic          lwk_prev;
    logic          bwk_arm;
    logic [CW-1:0] bwk_cnt;
    logic          wake_flag;
    logic [CW-1:0] txlo_cnt;
    logic          txto;
    logic [CW-1:0] short_cnt;
    logic          short_f;
    logic [CW-1:0] clamp_cnt;
    logic          clamp;
    logic [CW-1:0] dom_cnt;
    logic          dom_fail;
    logic [2:0]    fail_cnt;
    logic          bus_fail;
    logic          drv;
    logic          txdom;
    logic          sup_sw;
    logic          rxd;
    logic          fault_n;
  } cwfc_st_t;
endpackage

// [verilog/cwfc_filt.sv]
module cwfc_filt import cwfc_pkg::*; #(
  parameter logic [CW-1:0] FILT    = 16'h0001,
  parameter logic          RST_VAL = 1'b0
) (
  input  wire logic clock,  // System clock
  input  wire logic rstn,   // Async reset, active low
  input  wire logic raw,    // Pin as it arrives
  output logic      lvl     // Synchronised, filtered level
);
  cwfc_filt_st_t st, n;

  if (FILT == '0) begin : g_bad
    $error("cwfc_filt: FILT must be at least one");
  end

  // First stage feeds only the second
  always_comb begin
    n    = st;
    n.s1 = raw;
    n.s2 = st.s1;
    if (st.s2 == st.lvl) begin
      n.cnt = '0;
    end else if (st.cnt >= FILT - 16'h1) begin
      n.lvl = st.s2;
      n.cnt = '0;
    end else begin
      n.cnt = st.cnt + 16'h1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st <= '{s1: RST_VAL, s2: RST_VAL, lvl: RST_VAL, cnt: '0};
    end else begin
      st <= n;
    end
  end

  assign lvl = st.lvl;
endmodule

// [verilog/cwfc_top.sv]
// Operation
// - Sleep goes to standby after edge then dominant longer than bus filter.
// - Dominant phase shorter than bus wake filter is dropped as spike.
// - Permanent dominant without recessive-to-dominant edge never wakes.
// - In standby after wake, receive output and fault output go low.
// - Supply switch output is active once standby is entered.
// - Both edges of the local wake pin wake from sleep.
// - Wake pin change counts only if stable for the pin filter time.
// - Mode pins act only while logic and I/O supplies are present.
// - Sleep goes to normal or receive-only by pins, standby by wake or battery undervoltage.
// - Both mode pins high from sleep enter normal mode.
// - Bus short check only in normal mode while driving dominant.
// - Bus failure shown after four failing driven dominant bits.
// - Bus failure only reported; driver stays enabled.
// - Local failures shown on fault output only in receive-only mode.
// - Transmit low past time-out in normal disables driver, sets flag.
// - Time-out cleared by receive-only to normal with transmit high.
// - Transmit-to-receive short disables driver and sets flag.
// - Short flag cleared by receive-only to normal change.
// - Receive output stuck high sets flag and disables driver.
// - Clamp released when it disappears, or by a mode change taken while receive output is high.
// - Battery undervoltage also takes the device out of sleep.
// - Standby pin high: select high is normal, low is receive-only.
// - Standby pin low, select high starts go-to-sleep; timeout sleeps.
// - Logic or I/O undervoltage forces sleep from any mode unless battery undervoltage is also present.
module cwfc_top import cwfc_pkg::*; #(
  parameter logic [CW-1:0] BUS_WAKE = CW'(BUS_WAKE_CYC),
  parameter logic [CW-1:0] PIN_WAKE = CW'(PIN_WAKE_CYC),
  parameter logic [CW-1:0] TXD_TO   = CW'(TXD_TO_CYC),
  parameter logic [CW-1:0] CLAMP_T  = CW'(CLAMP_CYC),
  parameter logic [CW-1:0] SHORT_T  = CW'(SHORT_CYC),
  parameter logic [CW-1:0] SLEEP_T  = CW'(SLEEP_CYC),
  parameter logic [CW-1:0] BIT_MIN  = CW'(BIT_MIN_CYC)
) (
  input  wire logic  clock,                  // 20 MHz clock
  input  wire logic  rstn,                   // Async reset, active low
  input  wire logic  sleep_control_pin_n,    // Standby control pin
  input  wire logic  mode_select,            // Mode select pin
  input  wire logic  local_wake_pin,         // Local wake input
  input  wire logic  txd_in,                 // Transmit data, low dominant
  input  wire logic  bus_dominant_in,        // Bus receiver, high dominant
  input  wire logic  rxd_readback,           // Level seen on receive pin
  input  wire logic  bus_fault_sense,        // Bus short comparator
  input  wire logic  vcc_vio_uv,             // Filtered logic/I/O undervolt
  input  wire logic  vbat_uv,                // Battery undervoltage
  output logic       rxd_out,                // Receive output
  output logic       fault_flag_out_n,       // Fault flag, active low
  output logic       external_supply_switch, // Supply switch enable
  output logic       driver_enable,          // Output stage enabled
  output logic       tx_dominant,            // Drive dominant on bus
  output cwfc_stat_t status                  // Mode and flags
);
  cwfc_st_t         st, n;
  logic [NPINS-1:0] raw, pin;
  logic             bus_wake, lwk_wake, wake, lp_on, sup_ok, drv_dom;
  logic             slpn_s, en_s, lwk_s, txd_s, bus_s, rxrb_s, bfs_s;

  if (BUS_WAKE == '0 || PIN_WAKE == '0 || TXD_TO == '0 ||
      CLAMP_T == '0 || SHORT_T == '0 || SLEEP_T == '0 ||
      BIT_MIN == '0) begin : g_bad
    $error("cwfc_top: every count must be at least one");
  end

  assign raw = {bus_fault_sense, rxd_readback, bus_dominant_in, txd_in,
                local_wake_pin, mode_select, sleep_control_pin_n};

  for (genvar i = 0; i < NPINS; i++) begin : g_pin
    cwfc_filt #(
      .FILT    (i == P_LWK ? PIN_WAKE : 16'h0001),
      .RST_VAL (PIN_RST[i])
    ) u_filt (
      .clock (clock),
      .rstn  (rstn),
      .raw   (raw[i]),
      .lvl   (pin[i])
    );
  end

  assign slpn_s = pin[P_SLPN];
  assign en_s   = pin[P_EN];
  assign lwk_s  = pin[P_LWK];
  assign txd_s  = pin[P_TXD];
  assign bus_s  = pin[P_BUS];
  assign rxrb_s = pin[P_RXRB];
  assign bfs_s  = pin[P_BFS];

  always_comb begin
    n          = st;
    n.bus_prev = bus_s;
    n.lwk_prev = lwk_s;
    bus_wake   = 1'b0;
    sup_ok     = !vcc_vio_uv;
    lp_on      = st.mode inside {M_SLEEP, M_STBY, M_GTS};
    // Wake detection only while the low power receiver listens
    if (!lp_on) begin
      n.bwk_arm = 1'b0;
      n.bwk_cnt = '0;
    end else if (bus_s && !st.bus_prev) begin
      n.bwk_arm = 1'b1;
      n.bwk_cnt = '0;
    end else if (st.bwk_arm) begin
      if (!bus_s) begin
        n.bwk_arm = 1'b0;
      end else if (st.bwk_cnt >= BUS_WAKE - 16'h1) begin
        bus_wake  = 1'b1;
        n.bwk_arm = 1'b0;
      end else begin
        n.bwk_cnt = st.bwk_cnt + 16'h1;
      end
    end
    lwk_wake = lp_on && (lwk_s != st.lwk_prev);
    wake     = bus_wake || lwk_wake;

    case (st.mode)
      M_SLEEP: begin
        if (wake) begin
          n.mode = M_STBY;
        end else if (sup_ok && slpn_s) begin
          n.mode = en_s ? M_NORM : M_RXO;
        end
      end
      M_STBY: begin
        if (sup_ok && slpn_s) begin
          n.mode = en_s ? M_NORM : M_RXO;
        end else if (sup_ok && en_s) begin
          n.mode = M_GTS;
        end
      end
      M_GTS: begin
        if (sup_ok && slpn_s) begin
          n.mode = en_s ? M_NORM : M_RXO;
        end else if (sup_ok && !en_s) begin
          n.mode = M_STBY;
        end else if (st.gts_cnt >= SLEEP_T - 16'h1) begin
          n.mode = M_SLEEP;
        end else begin
          n.gts_cnt = st.gts_cnt + 16'h1;
        end
      end
      M_NORM, M_RXO: begin
        if (sup_ok) begin
          case ({slpn_s, en_s})
            2'b11:   n.mode = M_NORM;
            2'b10:   n.mode = M_RXO;
            2'b01:   n.mode = M_GTS;
            default: n.mode = M_STBY;
          endcase
        end
      end
      default: n.mode = M_STBY;
    endcase
    if (vcc_vio_uv) begin
      n.mode = M_SLEEP;
    end
    // Battery undervoltage wins, even over logic supply loss
    if (vbat_uv) begin
      n.mode = M_STBY;
    end
    if (n.mode != M_GTS) begin
      n.gts_cnt = '0;
    end

    if (wake) begin
      n.wake_flag = 1'b1;
    end else if (n.mode inside {M_NORM, M_RXO}) begin
      n.wake_flag = 1'b0;
    end

    // Transmit time-out
    if (st.mode == M_NORM && !txd_s) begin
      if (st.txlo_cnt >= TXD_TO - 16'h1) begin
        n.txto = 1'b1;
      end else begin
        n.txlo_cnt = st.txlo_cnt + 16'h1;
      end
    end else begin
      n.txlo_cnt = '0;
    end
    // Receive pin dragged low while driven high: shorted to transmit
    if (st.mode == M_NORM && !txd_s && !rxrb_s && st.rxd) begin
      if (st.short_cnt >= SHORT_T - 16'h1) begin
        n.short_f = 1'b1;
      end else begin
        n.short_cnt = st.short_cnt + 16'h1;
      end
    end else begin
      n.short_cnt = '0;
    end
    if (st.mode == M_RXO && n.mode == M_NORM) begin
      n.short_f = 1'b0;
      if (txd_s) begin
        n.txto = 1'b0;
      end
    end
    // Receive pin stays high while driven low
    if (st.mode inside {M_NORM, M_RXO} && !st.rxd && rxrb_s) begin
      if (st.clamp_cnt >= CLAMP_T - 16'h1) begin
        n.clamp = 1'b1;
      end else begin
        n.clamp_cnt = st.clamp_cnt + 16'h1;
      end
    end else begin
      n.clamp_cnt = '0;
      if (!rxrb_s || n.mode != st.mode) begin
        n.clamp = 1'b0;
      end
    end

    // Bus short check per driven dominant bit
    drv_dom = st.drv && !txd_s;
    // Leaving normal mode drops any count taken on the way out
    if (st.mode != M_NORM || n.mode != M_NORM) begin
      n.dom_cnt  = '0;
      n.dom_fail = 1'b0;
      n.fail_cnt = '0;
      n.bus_fail = 1'b0;
    end else if (drv_dom) begin
      if (st.dom_cnt != '1) begin
        n.dom_cnt = st.dom_cnt + 16'h1;
      end
      n.dom_fail = st.dom_fail || bfs_s;
    end else if (st.dom_cnt != '0) begin
      n.dom_cnt  = '0;
      n.dom_fail = 1'b0;
      if (st.dom_cnt >= BIT_MIN) begin
        if (st.dom_fail) begin
          if (st.fail_cnt != FAIL_BITS) begin
            n.fail_cnt = st.fail_cnt + 3'h1;
          end
          n.bus_fail = (st.fail_cnt + 3'h1 >= FAIL_BITS);
        end else begin
          n.fail_cnt = '0;
          n.bus_fail = 1'b0;
        end
      end
    end

    // Bus failure deliberately absent from the driver gate
    n.drv   = n.mode == M_NORM && !n.txto && !n.short_f && !n.clamp;
    n.txdom = n.drv && !txd_s;
    n.sup_sw = n.mode != M_SLEEP;
    case (n.mode)
      M_NORM: begin
        n.rxd     = !bus_s;
        n.fault_n = !n.bus_fail;
      end
      M_RXO: begin
        n.rxd     = !bus_s;
        n.fault_n = !(n.txto || n.short_f || n.clamp);
      end
      M_STBY: begin
        n.rxd     = !n.wake_flag;
        n.fault_n = !n.wake_flag;
      end
      default: begin
        n.rxd     = 1'b1;
        n.fault_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st         <= '0;
      st.mode    <= M_STBY;
      st.bus_prev <= PIN_RST[P_BUS];
      st.lwk_prev <= PIN_RST[P_LWK];
      st.sup_sw   <= 1'b1;
      st.rxd     <= 1'b1;
      st.fault_n <= 1'b1;
    end else begin
      st <= n;
    end
  end

  assign rxd_out                = st.rxd;
  assign fault_flag_out_n       = st.fault_n;
  assign external_supply_switch = st.sup_sw;
  assign driver_enable          = st.drv;
  assign tx_dominant            = st.txdom;
  assign status = '{mode: st.mode, wake_flag: st.wake_flag,
                    local_fail: st.txto || st.short_f || st.clamp,
                    bus_fail: st.bus_fail};

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  property p_bwk_edge;
    bus_wake |-> st.bwk_arm && bus_s && $past(bus_s);
  endproperty
  a_bwk_edge: assert property (p_bwk_edge)
    else $error("bus wake without arming edge");

  property p_sleep_exit;
    st.mode == M_SLEEP && !wake && !vbat_uv |=> st.mode != M_STBY;
  endproperty
  a_sleep_exit: assert property (p_sleep_exit)
    else $error("sleep left for standby without wake");

  property p_wake_show;
    st.mode == M_STBY && st.wake_flag |-> !rxd_out && !fault_flag_out_n;
  endproperty
  a_wake_show: assert property (p_wake_show)
    else $error("standby wake not shown on outputs");

  property p_fail_four;
    $rose(st.bus_fail) |-> $past(st.fail_cnt) == 3'h3 && st.fail_cnt == 3'h4;
  endproperty
  a_fail_four: assert property (p_fail_four)
    else $error("bus failure flagged at wrong bit count");

  property p_fail_norm;
    st.fail_cnt != 3'h0 |-> st.mode == M_NORM && $past(st.mode) == M_NORM;
  endproperty
  a_fail_norm: assert property (p_fail_norm)
    else $error("bus failure counted outside normal mode");

  property p_drv_kept;
    st.bus_fail && st.mode == M_NORM && !status.local_fail
      |-> driver_enable;
  endproperty
  a_drv_kept: assert property (p_drv_kept)
    else $error("driver dropped for bus failure");

  property p_txto;
    st.mode == M_NORM && !txd_s && st.txlo_cnt == TXD_TO - 16'h1
      |=> st.txto ##0 !driver_enable;
  endproperty
  a_txto: assert property (p_txto)
    else $error("transmit time-out not taken");

  property p_rxo_fault;
    st.mode == M_RXO |-> fault_flag_out_n == !status.local_fail;
  endproperty
  a_rxo_fault: assert property (p_rxo_fault)
    else $error("receive-only fault output wrong");

  property p_uv_sleep;
    vcc_vio_uv && !vbat_uv |=> st.mode == M_SLEEP && !external_supply_switch;
  endproperty
  a_uv_sleep: assert property (p_uv_sleep)
    else $error("logic undervoltage did not force sleep");

  property p_vbat;
    vbat_uv |=> st.mode == M_STBY ##0 external_supply_switch;
  endproperty
  a_vbat: assert property (p_vbat)
    else $error("battery undervoltage did not force standby");
endmodule

// [sim/cwfc_host.sv]
module cwfc_host import cwfc_pkg::*; (
  input  wire logic clock,               // System clock
  input  wire logic rxd_out,             // Device receive output
  input  wire logic tx_dominant,         // Device drives dominant
  output logic      sleep_control_pin_n, // Standby control pin
  output logic      mode_select,         // Mode select pin
  output logic      txd_in,              // Transmit data, low dominant
  output wire logic rxd_readback,        // Level seen on receive pin
  output wire logic bus_dominant_in      // Bus level, high dominant
);
  timeunit 1ns;
  timeprecision 1ps;
  // Dominant from power-up, so no recessive-to-dominant edge seen at start
  logic bus_lvl  = 1'b1;
  logic echo     = 1'b0;
  logic short_lo = 1'b0;
  logic clamp_hi = 1'b0;

  initial begin
    sleep_control_pin_n = 1'b0;
    mode_select = 1'b0;
    txd_in = 1'b1;
  end

  // Bus follows our transmitter only while echo is on
  assign bus_dominant_in = bus_lvl | (echo & tx_dominant);
  // Injected faults: pin shorted to transmit pulls low, clamp pulls high
  assign rxd_readback = short_lo ? 1'b0 : (clamp_hi ? 1'b1 : rxd_out);

  // Only the mode pins change here; supplies are left as the caller set them
  task automatic set_pins(input logic slpn, input logic sel);
    @(negedge clock);
    sleep_control_pin_n = slpn;
    mode_select = sel;
  endtask

  // Callers never pass a width below the minimum bit time
  task automatic send_bit(input int width);
    @(negedge clock);
    txd_in = 1'b0;
    repeat (width) @(negedge clock);
    txd_in = 1'b1;
    repeat (width) @(negedge clock);
  endtask
endmodule

// [sim/cwfc_top_tb.sv]
module cwfc_top_tb import cwfc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CEIL     = 15000;
  localparam int WAIT_MAX = SLEEP_CYC + 40;
  logic       clock           = 1'b0;
  logic       rstn            = 1'b0;
  logic       local_wake_pin  = 1'b0;
  logic       bus_fault_sense = 1'b0;
  logic       vcc_vio_uv      = 1'b0;
  logic       vbat_uv         = 1'b0;
  logic       sleep_control_pin_n, mode_select, txd_in, rxd_readback;
  logic       bus_dominant_in, rxd_out, fault_flag_out_n;
  logic       external_supply_switch, driver_enable, tx_dominant;
  cwfc_stat_t status;
  int         n_errors    = 0;
  int         checks_done = 0;
  int         cycles      = 0;

`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  n_errors++; $display("mismatch t=%0t got %h exp %h", $time, g, e); \
  end end

  always #25 clock = ~clock;

  // Short check must finish inside the transmit time-out; BIT_MIN shortened to 4, others default
  cwfc_top #(
    .TXD_TO(16'h0010), .SHORT_T(16'h0008), .BIT_MIN(16'h0004)
  ) cwfc_top_i (
    .clock(clock), .rstn(rstn),
    .sleep_control_pin_n(sleep_control_pin_n), .mode_select(mode_select),
    .local_wake_pin(local_wake_pin), .txd_in(txd_in),
    .bus_dominant_in(bus_dominant_in), .rxd_readback(rxd_readback),
    .bus_fault_sense(bus_fault_sense), .vcc_vio_uv(vcc_vio_uv),
    .vbat_uv(vbat_uv), .rxd_out(rxd_out),
    .fault_flag_out_n(fault_flag_out_n),
    .external_supply_switch(external_supply_switch),
    .driver_enable(driver_enable), .tx_dominant(tx_dominant),
    .status(status)
  );

  cwfc_host cwfc_host_i (
    .clock(clock), .rxd_out(rxd_out), .tx_dominant(tx_dominant),
    .sleep_control_pin_n(sleep_control_pin_n), .mode_select(mode_select),
    .txd_in(txd_in), .rxd_readback(rxd_readback),
    .bus_dominant_in(bus_dominant_in)
  );

  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == CEIL) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic wait_mode(input cwfc_mode_t m);
    int i;
    i = 0;
    while (status.mode !== m && i < WAIT_MAX) begin
      @(negedge clock);
      i++;
    end
  endtask

  task automatic go(input logic slpn, input logic sel, input cwfc_mode_t m);
    cwfc_host_i.set_pins(slpn, sel);
    wait_mode(m);
    `CHK(status.mode, m)
  endtask

  // Pins parked at 00 afterwards so a later standby does not re-sleep
  task automatic goto_sleep();
    go(1'b0, 1'b1, M_SLEEP);
    `CHK(external_supply_switch, 1'b0)
    cwfc_host_i.set_pins(1'b0, 1'b0);
    cyc(10);
    `CHK(status.mode, M_SLEEP)
  endtask

  task automatic t_bus_wake();
    goto_sleep();
    cyc(30);
    `CHK(status.mode, M_SLEEP)
    cwfc_host_i.bus_lvl = 1'b0;
    cyc(10);
    cwfc_host_i.bus_lvl = 1'b1;
    cyc(BUS_WAKE_CYC - 4);
    cwfc_host_i.bus_lvl = 1'b0;
    cyc(20);
    `CHK(status.mode, M_SLEEP)
    cwfc_host_i.bus_lvl = 1'b1;
    cyc(BUS_WAKE_CYC - 4);
    `CHK(status.mode, M_SLEEP)
    wait_mode(M_STBY);
    `CHK(status.mode, M_STBY)
    cyc(1);
    `CHK(rxd_out, 1'b0)
    `CHK(fault_flag_out_n, 1'b0)
    `CHK(external_supply_switch, 1'b1)
    cwfc_host_i.bus_lvl = 1'b0;
  endtask

  // First pass wakes on a rising change, second on a falling one
  task automatic t_local_wake();
    for (int k = 0; k < 2; k++) begin
      goto_sleep();
      local_wake_pin = ~local_wake_pin;
      cyc(2);
      local_wake_pin = ~local_wake_pin;
      cyc(20);
      `CHK(status.mode, M_SLEEP)
      local_wake_pin = ~local_wake_pin;
      wait_mode(M_STBY);
      `CHK(status.mode, M_STBY)
    end
  endtask

  task automatic t_pins_uv();
    goto_sleep();
    go(1'b1, 1'b0, M_RXO);
    goto_sleep();
    go(1'b1, 1'b1, M_NORM);
    vcc_vio_uv = 1'b1;
    cyc(2);
    `CHK(status.mode, M_SLEEP)
    cwfc_host_i.set_pins(1'b1, 1'b0);
    cyc(10);
    `CHK(status.mode, M_SLEEP)
    vbat_uv = 1'b1;
    cyc(2);
    `CHK(status.mode, M_STBY)
    vbat_uv = 1'b0;
    vcc_vio_uv = 1'b0;
    go(1'b1, 1'b1, M_NORM);
    go(1'b0, 1'b1, M_GTS);
    go(1'b0, 1'b0, M_STBY);
    `CHK(external_supply_switch, 1'b1)
    `CHK(fault_flag_out_n, 1'b1)
    go(1'b1, 1'b1, M_NORM);
  endtask

  task automatic t_bus_fail();
    cwfc_host_i.echo = 1'b1;
    bus_fault_sense = 1'b1;
    repeat (3) cwfc_host_i.send_bit(6);
    cyc(6);
    `CHK(fault_flag_out_n, 1'b1)
    cwfc_host_i.send_bit(6);
    cyc(6);
    `CHK(fault_flag_out_n, 1'b0)
    `CHK(driver_enable, 1'b1)
    bus_fault_sense = 1'b0;
    go(1'b1, 1'b0, M_RXO);
    go(1'b1, 1'b1, M_NORM);
  endtask

  task automatic t_txd_timeout();
    cwfc_host_i.txd_in = 1'b0;
    cyc(30);
    `CHK(driver_enable, 1'b0)
    `CHK(tx_dominant, 1'b0)
    `CHK(status.local_fail, 1'b1)
    `CHK(fault_flag_out_n, 1'b1)
    cwfc_host_i.txd_in = 1'b1;
    cyc(6);
    `CHK(driver_enable, 1'b0)
    go(1'b1, 1'b0, M_RXO);
    `CHK(fault_flag_out_n, 1'b0)
    go(1'b1, 1'b1, M_NORM);
    cyc(1);
    `CHK(driver_enable, 1'b1)
    cwfc_host_i.echo = 1'b0;
  endtask

  // Stays under the transmit time-out so only the short is flagged
  task automatic t_short();
    cwfc_host_i.short_lo = 1'b1;
    cwfc_host_i.txd_in = 1'b0;
    cyc(14);
    `CHK(driver_enable, 1'b0)
    `CHK(status.local_fail, 1'b1)
    cwfc_host_i.short_lo = 1'b0;
    cwfc_host_i.txd_in = 1'b1;
    cyc(6);
    `CHK(driver_enable, 1'b0)
    go(1'b1, 1'b0, M_RXO);
    `CHK(fault_flag_out_n, 1'b0)
    go(1'b1, 1'b1, M_NORM);
    cyc(1);
    `CHK(driver_enable, 1'b1)
    `CHK(status.local_fail, 1'b0)
  endtask

  task automatic t_clamp();
    cwfc_host_i.bus_lvl = 1'b1;
    cwfc_host_i.clamp_hi = 1'b1;
    cyc(CLAMP_CYC + 8);
    `CHK(driver_enable, 1'b0)
    `CHK(status.local_fail, 1'b1)
    cwfc_host_i.clamp_hi = 1'b0;
    cyc(8);
    `CHK(driver_enable, 1'b1)
    `CHK(status.local_fail, 1'b0)
    cwfc_host_i.bus_lvl = 1'b0;
  endtask

  initial begin
    repeat (2) @(posedge clock);
    @(negedge clock);
    rstn = 1'b1;
    cyc(1);
    `CHK(external_supply_switch, 1'b1)
    cyc(BUS_WAKE_CYC + 8);
    `CHK(status.wake_flag, 1'b0)
    `CHK(rxd_out, 1'b1)
    t_bus_wake();
    t_local_wake();
    t_pins_uv();
    t_bus_fail();
    t_txd_timeout();
    t_short();
    t_clamp();
    end_sim();
  end
endmodule
